/* File: frpic_dev.sv */
// Device end: resume, power-down and identification command logic.
`timescale 1ns/100ps
module frpic_dev import frpic_pkg::*; #(
   parameter logic [7:0] MFR_ID = 8'h5a, // Arbitrary value.
   parameter logic [7:0] DEV_ID = 8'h15, // Arbitrary value.
   parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89ab_cdef // Arbitrary.
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   frpic_link_if.dev link,
   input wire logic core_start_i,
   input wire logic core_done_i,
   output logic busy_o,
   output logic suspend_flag_o,
   output logic powerdown_o,
   output logic suspend_req_o,
   output logic resume_req_o,
   output logic volatile_clear_o
);
   typedef enum {S_IDLE, S_OPC, S_HOLD, S_ADDR, S_DATA, S_IGN} frpic_st_t;
   typedef enum {W_NONE, W_SUS, W_RES, W_PDE, W_PDR} frpic_wait_t;

   frpic_st_t st;
   frpic_wait_t wt;
   logic [5:0] ls;
   logic [5:0] ls_d;
   logic [7:0] opc;
   logic [7:0] cnt;
   logic [23:0] addr;
   logic [23:0] next_addr;
   logic [63:0] out_sr;
   logic [3:0] dio;
   logic [3:0] dio_oe_n;
   logic [TMR_W-1:0] tmr;
   logic busy;
   logic suspend_flag;
   logic powerdown;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_high;
   logic exec;
   logic pd_any;
   logic tmr_done;
   logic acc_resume;
   logic acc_suspend;
   logic acc_pd;
   logic acc_release;
   logic [7:0] nop;
   logic [2:0] lanes;

   // Data pattern for an ID read; it rotates, so reads repeat.
   function automatic logic [63:0] id_pattern(input logic [7:0] op,
      input logic a0);
      unique case (op)
         OP_RELEASE: id_pattern = {8{DEV_ID}};
         OP_UNIQUE_ID: id_pattern = UNIQUE_ID;
         OP_MFR_ID: id_pattern = {4{MFR_ID, DEV_ID}};
         default: id_pattern = a0 ? {4{DEV_ID, MFR_ID}} :
            {4{MFR_ID, DEV_ID}};
      endcase
   endfunction

   // Link pins pass two flops before any logic sees them.
   frpic_sync #(.W(6), .RST(LINK_RST)) u_sync (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .d_i({link.sclk, link.cs_n, link.io}),
      .q_o(ls),
      .q_d_o(ls_d)
   );

   // Edge and command decode on the synchronised link.
   assign sclk_rise = ls[5] & ~ls_d[5];
   assign sclk_fall = ~ls[5] & ls_d[5];
   assign cs_high = ls[4];
   assign exec = cs_high & ~ls_d[4] & (st == S_HOLD);
   assign pd_any = powerdown | (wt == W_PDE) | (wt == W_PDR);
   assign tmr_done = (wt != W_NONE) && (tmr == '0);
   assign nop = {opc[6:0], ls[0]};
   assign lanes = cmd_lanes(opc);
   assign acc_resume = exec && opc == OP_RESUME && suspend_flag && !busy &&
      !pd_any && wt == W_NONE;
   // Suspend is taken only while busy and not yet suspended.
   assign acc_suspend = exec && opc == OP_SUSPEND && !suspend_flag && busy &&
      !pd_any && wt == W_NONE;
   assign acc_pd = exec && opc == OP_POWERDOWN && !suspend_flag &&
      !pd_any && wt == W_NONE;
   assign acc_release = exec && opc == OP_RELEASE && powerdown &&
      wt == W_NONE;

   // Address capture path, lane count taken from the opcode.
   always_comb begin
      unique case (lanes)
         3'h2: next_addr = {addr[21:0], ls[1:0]};
         3'h4: next_addr = {addr[19:0], ls[3:0]};
         default: next_addr = {addr[22:0], ls[0]};
      endcase
   end

   // One timer serves suspend, resume, entry and release latencies.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wt <= W_NONE;
         tmr <= '0;
      end else if (acc_suspend) begin
         wt <= W_SUS;
         tmr <= TMR_W'(SUSPEND_CYC - 1);
      end else if (acc_resume) begin
         wt <= W_RES;
         tmr <= TMR_W'(RESUME_BUSY_CYC - 1);
      end else if (acc_pd) begin
         wt <= W_PDE;
         tmr <= TMR_W'(PD_ENTRY_CYC - 1);
      end else if (acc_release) begin
         wt <= W_PDR;
         tmr <= TMR_W'(PD_RELEASE_CYC - 1);
      end else if (tmr_done) begin
         wt <= W_NONE;
      end else if (wt != W_NONE) begin
         tmr <= tmr - 1'b1;
      end
   end

   // Busy flag; a start in the same cycle as a clear wins.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy <= 1'b0;
      end else if (core_start_i || (tmr_done && wt == W_RES)) begin
         busy <= 1'b1;
      end else if ((core_done_i && !suspend_flag) ||
         (tmr_done && wt == W_SUS)) begin
         busy <= 1'b0;
      end
   end

   // Suspend and power-down state; reset models a power loss.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         suspend_flag <= 1'b0;
         powerdown <= 1'b0;
      end else begin
         if (acc_suspend) begin
            suspend_flag <= 1'b1;
         end else if (acc_resume) begin
            suspend_flag <= 1'b0;
         end
         if (tmr_done && wt == W_PDE) begin
            powerdown <= 1'b1;
         end else if (tmr_done && wt == W_PDR) begin
            powerdown <= 1'b0;
         end
      end
   end

   // Strobes to the array core and status register.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         suspend_req_o <= 1'b0;
         resume_req_o <= 1'b0;
         volatile_clear_o <= 1'b0;
      end else begin
         suspend_req_o <= acc_suspend;
         resume_req_o <= acc_resume;
         volatile_clear_o <= acc_pd;
      end
   end

   // Frame sequencer: opcode, prefix, then rotating data out.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= S_IDLE;
         opc <= '0;
         cnt <= '0;
         addr <= '0;
         out_sr <= '0;
      end else if (cs_high) begin
         st <= S_IDLE;
      end else begin
         unique case (st)
            S_IDLE: begin
               st <= S_OPC;
               cnt <= '0;
            end
            S_OPC: if (sclk_rise) begin
               opc <= nop;
               cnt <= cnt + 1'b1;
               if (cnt == OPC_CLKS - 1'b1) begin
                  cnt <= '0;
                  if (pd_any) begin
                     st <= (nop == OP_RELEASE) ? S_HOLD : S_IGN;
                  end else if (nop == OP_RESUME || nop == OP_SUSPEND ||
                     nop == OP_POWERDOWN) begin
                     st <= S_HOLD;
                  end else if (cmd_prefix(nop) != 8'h00) begin
                     st <= S_ADDR;
                  end else begin
                     st <= S_IGN;
                  end
               end
            end
            S_HOLD: if (sclk_rise) begin
               st <= S_IGN;
            end
            S_ADDR: if (sclk_rise) begin
               cnt <= cnt + 1'b1;
               if (cnt < cmd_addr_end(opc)) begin
                  addr <= next_addr;
               end
               if (cnt == cmd_prefix(opc) - 1'b1) begin
                  st <= S_DATA;
                  // address one starts with device ID for dual and quad ID reads only
                  out_sr <= id_pattern(opc, (cnt < cmd_addr_end(opc)) ?
                     next_addr[0] : addr[0]);
               end
            end
            S_DATA: if (sclk_fall) begin
               out_sr <= (out_sr << lanes) | (out_sr >> (7'd64 - lanes));
            end
            S_IGN: begin
            end
         endcase
      end
   end

   // Output lanes change on falling edges, MSB first.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dio <= '0;
         dio_oe_n <= OE_NONE;
      end else if (cs_high) begin
         dio_oe_n <= OE_NONE;
      end else if (st == S_DATA && sclk_fall) begin
         unique case (lanes)
            3'h2: begin
               dio <= {2'b00, out_sr[63:62]};
               dio_oe_n <= OE_DUAL;
            end
            3'h4: begin
               dio <= out_sr[63:60];
               dio_oe_n <= OE_QUAD;
            end
            default: begin
               dio <= {2'b00, out_sr[63], 1'b0};
               dio_oe_n <= OE_LANE1;
            end
         endcase
      end
   end

   assign link.dev_io = dio;
   assign link.dev_io_oe_n = dio_oe_n;
   assign busy_o = busy;
   assign suspend_flag_o = suspend_flag;
   assign powerdown_o = powerdown;
endmodule

/* File: frpic_host.sv */
// Host end: frames commands on the link and gathers read bytes.
`timescale 1ns/100ps
module frpic_host import frpic_pkg::*; (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   frpic_link_if.host link,
   input wire logic cmd_valid_i,
   input wire logic [7:0] cmd_op_i,
   input wire logic [23:0] cmd_addr_i,
   input wire logic [7:0] cmd_bytes_i,
   output logic cmd_ready_o,
   output logic [7:0] rd_data_o,
   output logic rd_valid_o,
   output logic done_o
);
   typedef enum {H_IDLE, H_WAIT, H_RUN, H_GAP} frpic_hst_t;

   frpic_hst_t st;
   logic [3:0] rio;
   logic [7:0] op;
   logic [55:0] tx;
   logic [2:0] lanes;
   logic [CNT_W-1:0] pre;
   logic [CNT_W-1:0] tot;
   logic [CNT_W-1:0] idx;
   logic [2:0] hc;
   logic phase;
   logic [TMR_W-1:0] gap;
   logic [TMR_W-1:0] guard;
   logic [7:0] rx;
   logic [7:0] next_rx;
   logic [3:0] rxb;
   logic noarg;
   logic cs_n;
   logic sclk;
   logic [3:0] hio;
   logic [3:0] hoe_n;
   logic [1:0] sh;
   logic [CNT_W-1:0] nidx;

   // Prefix bits after the opcode, left aligned.
   function automatic logic [47:0] host_prefix(input logic [7:0] o,
      input logic [23:0] a);
      unique case (o)
         OP_MFR_ID_DUAL: host_prefix = {a, MODE_BITS, 16'h0000};
         OP_MFR_ID_QUAD: host_prefix = {16'h0000, a, MODE_BITS};
         OP_MFR_ID: host_prefix = {a, 24'h000000};
         default: host_prefix = 48'h0;
      endcase
   endfunction

   // Returned data is from outside this clock; two flops first.
   frpic_sync #(.W(4), .RST(OE_NONE)) u_sync (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .d_i(link.io),
      .q_o(rio),
      .q_d_o()
   );

   // A zero byte count gives an opcode-only frame; any other count adds
   // clocks, so a frame with stray clocks can be made on purpose.
   assign noarg = cmd_bytes_i == 8'h00;
   assign sh = (cmd_lanes(cmd_op_i) == 3'h4) ? 2'd2 :
      (cmd_lanes(cmd_op_i) == 3'h2) ? 2'd1 : 2'd0;
   assign nidx = idx + 1'b1;

   // Sampled lanes shifted into the byte being assembled.
   always_comb begin
      unique case (lanes)
         3'h2: next_rx = {rx[5:0], rio[1:0]};
         3'h4: next_rx = {rx[3:0], rio[3:0]};
         default: next_rx = {rx[6:0], rio[1]};
      endcase
   end

   // Frame sequencer; link clock is the local clock divided down.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= H_IDLE;
         cmd_ready_o <= 1'b1;
         done_o <= 1'b0;
         rd_valid_o <= 1'b0;
         rd_data_o <= '0;
         op <= '0;
         tx <= '0;
         lanes <= 3'h1;
         pre <= '0;
         tot <= '0;
         idx <= '0;
         hc <= '0;
         phase <= 1'b0;
         gap <= '0;
         guard <= '0;
         rx <= '0;
         rxb <= '0;
         cs_n <= 1'b1;
         sclk <= 1'b0;
         hio <= '0;
         hoe_n <= OE_NONE;
      end else begin
         done_o <= 1'b0;
         rd_valid_o <= 1'b0;
         if (guard != '0) begin
            guard <= guard - 1'b1;
         end
         unique case (st)
            H_IDLE: if (cmd_valid_i) begin
               cmd_ready_o <= 1'b0;
               st <= H_WAIT;
               op <= cmd_op_i;
               tx <= {cmd_op_i, host_prefix(cmd_op_i, cmd_addr_i)};
               lanes <= cmd_lanes(cmd_op_i);
               // no-argument frames end after the opcode
               pre <= noarg ? CNT_W'(OPC_CLKS) :
                  CNT_W'(OPC_CLKS + cmd_prefix(cmd_op_i));
               tot <= noarg ? CNT_W'(OPC_CLKS) :
                  CNT_W'(OPC_CLKS + cmd_prefix(cmd_op_i)) +
                  (CNT_W'({cmd_bytes_i, 3'b000}) >> sh);
            end
            // suspend waits out latency after resume
            H_WAIT: if (!(op == OP_SUSPEND && guard != '0)) begin
               st <= H_RUN;
               cs_n <= 1'b0;
               sclk <= 1'b0;
               hio <= {3'b000, tx[55]};
               hoe_n <= OE_LANE0;
               tx <= tx << 1;
               idx <= '0;
               hc <= '0;
               phase <= 1'b0;
               rxb <= '0;
            end
            H_RUN: if (hc == 3'(SCLK_HALF_CYC - 1)) begin
               hc <= '0;
               phase <= ~phase;
               if (!phase) begin
                  sclk <= 1'b1;
               end else begin
                  sclk <= 1'b0;
                  if (idx >= pre) begin
                     rx <= next_rx;
                     rxb <= (rxb + 4'(lanes) == 4'h8) ? 4'h0 :
                        rxb + 4'(lanes);
                     if (rxb + 4'(lanes) == 4'h8) begin
                        rd_data_o <= next_rx;
                        rd_valid_o <= 1'b1;
                     end
                  end
                  idx <= nidx;
                  if (nidx == tot) begin
                     st <= H_GAP;
                     cs_n <= 1'b1;
                     hoe_n <= OE_NONE;
                     gap <= (op == OP_RELEASE && pre == CNT_W'(OPC_CLKS)) ?
                        TMR_W'(PD_RELEASE_HOST_CYC) : TMR_W'(CS_HIGH_CYC);
                     if (op == OP_RESUME) begin
                        guard <= TMR_W'(SUSPEND_HOST_CYC);
                     end
                  end else if (nidx < CNT_W'(OPC_CLKS)) begin
                     hio <= {3'b000, tx[55]};
                     tx <= tx << 1;
                  end else if (nidx < pre) begin
                     unique case (lanes)
                        3'h2: hio <= {2'b00, tx[55:54]};
                        3'h4: hio <= tx[55:52];
                        default: hio <= {3'b000, tx[55]};
                     endcase
                     hoe_n <= (lanes == 3'h4) ? OE_QUAD :
                        (lanes == 3'h2) ? OE_DUAL : OE_LANE0;
                     tx <= tx << lanes;
                  end else begin
                     hoe_n <= OE_NONE;
                  end
               end
            end else begin
               hc <= hc + 1'b1;
            end
            H_GAP: if (gap == '0) begin
               st <= H_IDLE;
               cmd_ready_o <= 1'b1;
               done_o <= 1'b1;
            end else begin
               gap <= gap - 1'b1;
            end
         endcase
      end
   end

   assign link.cs_n = cs_n;
   assign link.sclk = sclk;
   assign link.host_io = hio;
   assign link.host_io_oe_n = hoe_n;
endmodule

/* File: frpic_link_if.sv */
// Serial flash link between host controller and device command logic.
`timescale 1ns/100ps
interface frpic_link_if;
   logic cs_n;
   logic sclk;
   logic [3:0] host_io;
   logic [3:0] host_io_oe_n;
   logic [3:0] dev_io;
   logic [3:0] dev_io_oe_n;
   logic [3:0] io;

   // Wire level per lane: device wins, then host, else pulled high.
   assign io = (~dev_io_oe_n & dev_io) |
      (dev_io_oe_n & ~host_io_oe_n & host_io) |
      (dev_io_oe_n & host_io_oe_n);

   modport dev (input cs_n, input sclk, input io,
      output dev_io, output dev_io_oe_n);
   modport host (output cs_n, output sclk, output host_io,
      output host_io_oe_n, input io);
endinterface

/* File: frpic_link_properties.sv */
// Concurrent checks on the serial link between host and device ends.
`timescale 1ns/100ps
module frpic_link_properties import frpic_pkg::*; (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic [3:0] host_io,
   input wire logic [3:0] host_io_oe_n,
   input wire logic [3:0] dev_io,
   input wire logic [3:0] dev_io_oe_n,
   input wire logic [3:0] io
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
      else $error("link clock moved outside a frame");
   AST_HOST_DI_STABLE: assert property
      (!cs_n && sclk && $past(sclk) |-> $stable(host_io))
      else $error("host lanes moved while link clock high");
   AST_DEV_SHIFT_LOW: assert property
      (!cs_n && sclk && $past(sclk) |-> $stable(dev_io))
      else $error("device lanes moved while link clock high");
   AST_NO_CONTENTION: assert property
      ((~dev_io_oe_n & ~host_io_oe_n) == 4'h0)
      else $error("both ends drive one lane");
   AST_BUS_IDLE_HIGH: assert property (cs_n [*5] |-> io == 4'hf)
      else $error("lanes not pulled high after deselect");
   AST_DEV_RELEASE: assert property (cs_n [*5] |-> dev_io_oe_n == OE_NONE)
      else $error("device drives lanes after deselect");
   AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
      else $error("link clock high phase is not four cycles");
   AST_SCLK_LOW: assert property ($fell(sclk) |-> !sclk [*4])
      else $error("link clock low phase is short");
   AST_CS_GAP: assert property ($rose(cs_n) |-> cs_n [*5])
      else $error("chip select high gap too short");
   AST_HOST_OPCODE: assert property ($fell(cs_n) |-> !host_io_oe_n[0])
      else $error("host does not drive the data input lane");
   // Main transfers: single, dual and quad reads from the device.
   cover property (dev_io_oe_n == OE_LANE1);
   cover property (dev_io_oe_n == OE_DUAL);
   cover property (dev_io_oe_n == OE_QUAD);
endmodule

/* File: frpic_pkg.sv */
// Shared opcodes, link timing and command framing for the flash ID block.
package frpic_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int LINK_PERIOD_NS = 80;
   localparam int SCLK_HALF_CYC = LINK_PERIOD_NS / 2 / CLK_PERIOD_NS;
   localparam int CS_HIGH_NS = 50;
   localparam int CS_HIGH_CYC = (CS_HIGH_NS + CLK_PERIOD_NS - 1) /
      CLK_PERIOD_NS;
   localparam int RESUME_BUSY_NS = 200;
   localparam int RESUME_BUSY_CYC = RESUME_BUSY_NS / CLK_PERIOD_NS;
   localparam int SUSPEND_LATENCY_NS = 20000;
   localparam int SUSPEND_CYC = SUSPEND_LATENCY_NS / CLK_PERIOD_NS;
   localparam int SUSPEND_HOST_CYC = (SUSPEND_LATENCY_NS +
      CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POWERDOWN_ENTRY_TIME_NS = 3000;
   localparam int PD_ENTRY_CYC = POWERDOWN_ENTRY_TIME_NS / CLK_PERIOD_NS;
   localparam int POWERDOWN_RELEASE_TIME_NS = 3000;
   localparam int PD_RELEASE_CYC = POWERDOWN_RELEASE_TIME_NS /
      CLK_PERIOD_NS;
   localparam int PD_RELEASE_HOST_CYC = (POWERDOWN_RELEASE_TIME_NS +
      CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TMR_W = 12;
   localparam int CNT_W = 12;
   localparam logic [7:0] OP_RESUME = 8'h7a;
   localparam logic [7:0] OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_POWERDOWN = 8'hb9;
   localparam logic [7:0] OP_RELEASE = 8'hab;
   localparam logic [7:0] OP_MFR_ID = 8'h90;
   localparam logic [7:0] OP_MFR_ID_DUAL = 8'h92;
   localparam logic [7:0] OP_MFR_ID_QUAD = 8'h94;
   localparam logic [7:0] OP_UNIQUE_ID = 8'h4b;
   localparam logic [7:0] MODE_BITS = 8'hf0;
   localparam logic [7:0] OPC_CLKS = 8'h08;
   localparam logic [3:0] OE_NONE = 4'hf;
   localparam logic [3:0] OE_LANE0 = 4'he;
   localparam logic [3:0] OE_LANE1 = 4'hd;
   localparam logic [3:0] OE_DUAL = 4'hc;
   localparam logic [3:0] OE_QUAD = 4'h0;
   localparam logic [5:0] LINK_RST = 6'h1f;

   // Clocks after the opcode before the first data clock.
   function automatic logic [7:0] cmd_prefix(input logic [7:0] op);
      unique case (op)
         OP_MFR_ID, OP_RELEASE: cmd_prefix = 8'h18;
         OP_MFR_ID_DUAL: cmd_prefix = 8'h10;
         OP_MFR_ID_QUAD: cmd_prefix = 8'h0c;
         OP_UNIQUE_ID: cmd_prefix = 8'h20;
         default: cmd_prefix = 8'h00;
      endcase
   endfunction

   // Prefix clock count at which the address has fully arrived.
   function automatic logic [7:0] cmd_addr_end(input logic [7:0] op);
      unique case (op)
         OP_MFR_ID: cmd_addr_end = 8'h18;
         OP_MFR_ID_DUAL: cmd_addr_end = 8'h0c;
         OP_MFR_ID_QUAD: cmd_addr_end = 8'h0a;
         default: cmd_addr_end = 8'h00;
      endcase
   endfunction

   // Lanes used for address and data of a command.
   function automatic logic [2:0] cmd_lanes(input logic [7:0] op);
      unique case (op)
         OP_MFR_ID_DUAL: cmd_lanes = 3'h2;
         OP_MFR_ID_QUAD: cmd_lanes = 3'h4;
         default: cmd_lanes = 3'h1;
      endcase
   endfunction
endpackage

/* File: frpic_sync.sv */
// Two-flop synchroniser with one extra stage for edge detection.
`timescale 1ns/100ps
module frpic_sync #(
   parameter int W = 6,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o,
   output logic [W-1:0] q_d_o
);
   logic [W-1:0] meta;

   // The first stage is never read; the third gives the previous value.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta <= RST;
         q_o <= RST;
         q_d_o <= RST;
      end else begin
         meta <= d_i;
         q_o <= meta;
         q_d_o <= q_o;
      end
   end
endmodule

/* File: testbench.sv */
// Self-checking bench joining host and device ends over the serial link.
`timescale 1ns/100ps
module testbench import frpic_pkg::*;;
   localparam logic [7:0] MFR = 8'h5a; // Arbitrary value.
   localparam logic [7:0] DEV = 8'h15; // Arbitrary value.
   localparam logic [63:0] UID = 64'hfedc_ba98_7654_3210; // Arbitrary.
   typedef struct packed {
      logic [7:0] op;
      logic [23:0] a;
      logic [7:0] n;
      logic [63:0] e;
   } frpic_row_t;
   frpic_row_t rows[7] = '{'{OP_RELEASE, 24'h0, 8'h2, {DEV, DEV, 48'h0}},
      '{OP_MFR_ID, 24'h0, 8'h3, {MFR, DEV, MFR, 40'h0}},
      '{OP_MFR_ID_DUAL, 24'h0, 8'h2, {MFR, DEV, 48'h0}},
      '{OP_MFR_ID_DUAL, 24'h1, 8'h3, {DEV, MFR, DEV, 40'h0}},
      '{OP_MFR_ID_QUAD, 24'h0, 8'h2, {MFR, DEV, 48'h0}},
      '{OP_MFR_ID_QUAD, 24'h1, 8'h2, {DEV, MFR, 48'h0}},
      '{OP_UNIQUE_ID, 24'h0, 8'h8, UID}};
   logic mclk = 0, rst_n = 0, cv = 0, st = 0, dn = 0;
   logic [7:0] op = 0, nb = 0, rdd;
   logic [23:0] ad = 0;
   logic rdy, rdv, dne, busy, susp, pd, sreq, rreq, vclr;
   int num_errors = 0, n_tests = 0, cyc = 0, n_res = 0, n_vc = 0, n_sq = 0;
   int t_up = 0, cs_gap = 0;
   logic cs_q = 1;
   logic [7:0] got[$];
   frpic_link_if link();
   frpic_dev #(.MFR_ID(MFR), .DEV_ID(DEV), .UNIQUE_ID(UID)) frpic_dev_i (
      .mclk_i(mclk), .rst_n_i(rst_n), .link(link), .core_start_i(st),
      .core_done_i(dn), .busy_o(busy), .suspend_flag_o(susp),
      .powerdown_o(pd), .suspend_req_o(sreq), .resume_req_o(rreq),
      .volatile_clear_o(vclr));
   frpic_host frpic_host_i (.mclk_i(mclk), .rst_n_i(rst_n), .link(link),
      .cmd_valid_i(cv), .cmd_op_i(op), .cmd_addr_i(ad), .cmd_bytes_i(nb),
      .cmd_ready_o(rdy), .rd_data_o(rdd), .rd_valid_o(rdv), .done_o(dne));
   frpic_link_properties frpic_link_properties_i (.mclk_i(mclk),
      .rst_n_i(rst_n), .cs_n(link.cs_n), .sclk(link.sclk),
      .host_io(link.host_io), .host_io_oe_n(link.host_io_oe_n),
      .dev_io(link.dev_io), .dev_io_oe_n(link.dev_io_oe_n), .io(link.io));
   // The system clock toggles every half period.
   initial begin
      forever #5 mclk = ~mclk;
   end
   task automatic tally_and_finish;
      if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      n_tests++;
      if (seen !== want) begin
         num_errors++;
         $display("wrong value at %0t: seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic tick(input int c);
      repeat (c) begin
         @(posedge mclk);
         #1;
      end
   endtask
   // Pulses arrive one cycle wide, so the falling edge counts them safely.
   // The select gap before each frame is measured in clock cycles too.
   always @(negedge mclk) begin
      cyc++;
      if (link.cs_n === 1'b1 && cs_q === 1'b0) t_up = cyc;
      if (link.cs_n === 1'b0 && cs_q === 1'b1) cs_gap = cyc - t_up;
      cs_q = link.cs_n;
      if (rreq === 1'b1) n_res++;
      if (vclr === 1'b1) n_vc++;
      if (sreq === 1'b1) n_sq++;
      if (cyc == 60000) begin
         num_errors++;
         tally_and_finish;
      end
   end
   // Offers one command, holds it until the frame starts, gathers bytes.
   task automatic run(input logic [7:0] o, input logic [23:0] a,
      input logic [7:0] n);
      int k;
      got.delete();
      op = o;
      ad = a;
      nb = n;
      cv = 1;
      for (k = 0; k < 3000 && link.cs_n !== 1'b0; k++) tick(1);
      cv = 0;
      for (k = 0; k < 4000 && dne !== 1'b1; k++) begin
         tick(1);
         if (rdv === 1'b1) got.push_back(rdd);
      end
   endtask
   task automatic pulse(input bit s);
      st = s;
      dn = !s;
      tick(1);
      st = 0;
      dn = 0;
   endtask
   // Main sequence: table of reads, then flag and power-down cases.
   initial begin
      tick(8);
      rst_n = 1;
      tick(4);
      chk(pd, 0);
      foreach (rows[i]) begin
         run(rows[i].op, rows[i].a, rows[i].n);
         chk(8'(got.size()), rows[i].n);
         for (int j = 0; j < got.size(); j++)
            chk(got[j], rows[i].e[63-8*j -: 8]);
      end
      run(OP_RESUME, 24'h0, 8'h0);
      chk(8'(n_res), 0);
      pulse(1);
      run(OP_RESUME, 24'h0, 8'h0);
      chk(8'(n_res), 0);
      run(OP_SUSPEND, 24'h0, 8'h0);
      chk({susp, 7'(n_sq)}, 8'h81);
      chk({rdy, 7'(cs_gap >= SUSPEND_CYC)}, 8'h81);
      tick(2100);
      chk(busy, 0);
      run(OP_POWERDOWN, 24'h0, 8'h0);
      tick(400);
      chk({pd, 7'(n_vc)}, 8'h0);
      run(OP_RESUME, 24'h0, 8'h0);
      chk({susp, 7'(n_res)}, 8'h1);
      tick(25);
      chk(busy, 1);
      pulse(0);
      run(OP_POWERDOWN, 24'h0, 8'h1);
      tick(400);
      chk({pd, 7'(n_vc)}, 8'h0);
      run(OP_POWERDOWN, 24'h0, 8'h0);
      chk(8'(n_vc), 1);
      tick(310);
      chk(pd, 1);
      run(OP_MFR_ID, 24'h0, 8'h1);
      chk(got[0], 8'hff);
      run(OP_RELEASE, 24'h0, 8'h0);
      tick(310);
      chk(pd, 0);
      pulse(1);
      run(OP_SUSPEND, 24'h0, 8'h0);
      rst_n = 0;
      tick(8);
      rst_n = 1;
      tick(4);
      chk({susp, pd}, 0);
      run(OP_RESUME, 24'h0, 8'h0);
      chk({busy, 7'(n_res)}, 8'h1);
      tally_and_finish;
   end
endmodule
